// ==== rtl/queue_pkg.sv ====
package queue_pkg;

    // Queue shape
    localparam int unsigned DATA_W        = 8;
    localparam int unsigned DEPTH         = 16;
    localparam int unsigned IDX_W         = 4;
    localparam int unsigned PTR_W         = 5;
    localparam logic [4:0]  ALMOST_FULL   = 5'h0E;
    localparam logic [4:0]  ALMOST_EMPTY  = 5'h02;
    localparam logic [4:0]  LEVEL_FULL    = 5'h10;
    localparam logic [4:0]  LEVEL_ONE     = 5'h01;
    localparam logic [4:0]  LEVEL_LAST    = 5'h0F;

    // Synchroniser chain
    localparam int unsigned MAX_STAGES    = 8;
    localparam logic [3:0]  STAGES_LOWEST = 4'h1;
    localparam logic [3:0]  STAGES_MIN    = 4'h2;
    localparam logic [3:0]  STAGES_BEST   = 4'h3;
    localparam logic [3:0]  STAGES_CAP    = 4'h8;
    localparam logic [3:0]  DEPTH_SCALE   = 4'h2;
    localparam logic [3:0]  PIPE_DEFAULT  = 4'h3;

    typedef enum logic [1:0] {
        GROUP_LOWEST = 2'b00,
        GROUP_MIN    = 2'b01,
        GROUP_BEST   = 2'b10,
        GROUP_DEPTH  = 2'b11
    } sync_group_t;

    // Register map (byte addresses)
    localparam int unsigned ADDR_W        = 8;
    localparam logic [7:0]  CTRL_OFF      = 8'h00;
    localparam logic [7:0]  STATUS_OFF    = 8'h04;
    localparam logic [7:0]  IRQ_STAT_OFF  = 8'h08;
    localparam logic [7:0]  IRQ_MASK_OFF  = 8'h0C;
    localparam logic [7:0]  SYNC_OFF      = 8'h10;

    // Control fields
    localparam int unsigned CTRL_W        = 13;
    localparam int unsigned LA_BIT        = 0;
    localparam int unsigned OREG_BIT      = 1;
    localparam int unsigned GROUP_LSB     = 2;
    localparam int unsigned NEWER_BIT     = 4;
    localparam int unsigned WDEPTH_LSB    = 5;
    localparam int unsigned RDEPTH_LSB    = 9;
    localparam logic [12:0] CTRL_RESET    = 13'h0671;

    // Interrupt events
    localparam int unsigned IRQ_W         = 4;
    localparam int unsigned EV_FULL       = 0;
    localparam int unsigned EV_DRAINED    = 1;
    localparam int unsigned EV_OVERFLOW   = 2;
    localparam int unsigned EV_UNDERFLOW  = 3;

    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

endpackage

// ==== rtl/queue_sync_clear.sv ====
// Operation
// - Lowest-latency group: one unprotected sync stage
// - Minimal unsynchronized group: two sync stages
// - Best-protection group: three or more stages
// - Newer generation: stages equal pipe depth minus two
// - Newer generation: depth 3 one, 4 two
// - Cross-domain latency adds one cycle per stage
// - Accept synchronous and asynchronous clear inputs
// - Clear: full low, empty high, level zero
// - Either clear zeroes read and write pointers
// - Synchronous clear acts only at clock edge
// - Asynchronous clear hits flags, pointers immediately
// - Normal sclr: unregistered shows first word
// - Look-ahead sclr: hold one cycle, then first
// - Normal aclr: read data keeps its value
// - Look-ahead aclr: unregistered shows first word next edge
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module queue_sync_clear (
    input  wire logic        aclk,          // System clock
    input  wire logic        aresetn,       // Sync reset, active low
    input  wire logic [7:0]  awaddr,        // AXI write address
    input  wire logic        awvalid,       // AXI write address valid
    output logic             awready,       // AXI write address ready
    input  wire logic [31:0] wdata,         // AXI write data
    input  wire logic [3:0]  wstrb,         // AXI write strobes
    input  wire logic        wvalid,        // AXI write data valid
    output logic             wready,        // AXI write data ready
    output logic [1:0]       bresp,         // AXI write response
    output logic             bvalid,        // AXI write response valid
    input  wire logic        bready,        // AXI write response ready
    input  wire logic [7:0]  araddr,        // AXI read address
    input  wire logic        arvalid,       // AXI read address valid
    output logic             arready,       // AXI read address ready
    output logic [31:0]      rdata,         // AXI read data
    output logic [1:0]       rresp,         // AXI read response
    output logic             rvalid,        // AXI read data valid
    input  wire logic        rready,        // AXI read data ready
    input  wire logic        sync_clear,    // Synchronous clear
    input  wire logic        async_clear,   // Asynchronous clear
    input  wire logic        wr_req,        // Write request
    input  wire logic [7:0]  wr_data,       // Write word
    input  wire logic        rd_req,        // Read request
    output logic [7:0]       rd_data,       // Read word
    output logic             empty,         // Queue empty
    output logic             full,          // Queue full
    output logic             almost_empty,  // Near-drained flag
    output logic             almost_full,   // Near-capacity flag
    output logic [4:0]       used_words,    // Fill level
    output logic [4:0]       remote_level,  // Level seen across sync chain
    output logic             irq            // Interrupt, active high
);

    ////////////////////////////////////////////////////////////////////////
    // Register bus
    logic                    awready_reg;
    logic                    wready_reg;
    logic                    bvalid_reg;
    logic [1:0]              bresp_reg;
    logic                    aw_held_reg;
    logic                    w_held_reg;
    logic [7:0]              aw_addr_reg;
    logic [31:0]             w_data_reg;
    logic [3:0]              w_strb_reg;
    logic                    arready_reg;
    logic                    rvalid_reg;
    logic [31:0]             rdata_reg;
    logic [1:0]              rresp_reg;
    logic [queue_pkg::CTRL_W-1:0] ctrl_reg;
    logic [queue_pkg::IRQ_W-1:0]  irq_stat_reg;
    logic [queue_pkg::IRQ_W-1:0]  irq_mask_reg;
    logic                    irq_reg;

    wire        wr_commit = aw_held_reg & w_held_reg & ~bvalid_reg;
    wire [31:0] wmask     = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                             {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
    wire [31:0] wmerged   = w_data_reg & wmask;
    wire        hit_ctrl  = aw_addr_reg == queue_pkg::CTRL_OFF;
    wire        hit_stat  = aw_addr_reg == queue_pkg::IRQ_STAT_OFF;
    wire        hit_mask  = aw_addr_reg == queue_pkg::IRQ_MASK_OFF;
    wire        hit_ro    = (aw_addr_reg == queue_pkg::STATUS_OFF)
                          | (aw_addr_reg == queue_pkg::SYNC_OFF);
    wire        wr_mapped = hit_ctrl | hit_stat | hit_mask | hit_ro;
    wire [queue_pkg::CTRL_W-1:0] ctrl_wmask = wmask[queue_pkg::CTRL_W-1:0];
    wire [queue_pkg::CTRL_W-1:0] ctrl_next =
        (ctrl_reg & ~ctrl_wmask) | wmerged[queue_pkg::CTRL_W-1:0];
    wire [queue_pkg::IRQ_W-1:0] stat_clr =
        (wr_commit & hit_stat) ? wmerged[queue_pkg::IRQ_W-1:0] : 4'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg  <= 32'h0000_0000;
            w_strb_reg  <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= queue_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready_reg) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= awaddr;
                awready_reg <= 1'b0;
            end
            if (wvalid && wready_reg) begin
                w_held_reg  <= 1'b1;
                w_data_reg  <= wdata;
                w_strb_reg  <= wstrb;
                wready_reg  <= 1'b0;
            end
            if (wr_commit) begin
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= wr_mapped ? queue_pkg::RESP_OKAY
                                         : queue_pkg::RESP_SLVERR;
            end
            if (bvalid_reg && bready) begin
                bvalid_reg  <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg  <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg     <= queue_pkg::CTRL_RESET;
            irq_mask_reg <= 4'h0;
        end else if (wr_commit) begin
            if (hit_ctrl)
                ctrl_reg <= ctrl_next;
            if (hit_mask)
                irq_mask_reg <= wmerged[queue_pkg::IRQ_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode decode and sync stage count
    wire       la_mode  = ctrl_reg[queue_pkg::LA_BIT];
    wire       oreg     = ctrl_reg[queue_pkg::OREG_BIT];
    wire [1:0] group    = ctrl_reg[queue_pkg::GROUP_LSB +: 2];
    wire       newer    = ctrl_reg[queue_pkg::NEWER_BIT];
    wire [3:0] wdepth   = ctrl_reg[queue_pkg::WDEPTH_LSB +: 4];
    wire [3:0] rdepth   = ctrl_reg[queue_pkg::RDEPTH_LSB +: 4];
    wire [3:0] depth_sc = (wdepth > queue_pkg::DEPTH_SCALE)
                        ? wdepth - queue_pkg::DEPTH_SCALE : 4'h1;
    wire [3:0] depth_st = newer ? depth_sc : wdepth;
    wire [3:0] depth_cl = (depth_st == 4'h0) ? 4'h1
                        : (depth_st > queue_pkg::STAGES_CAP)
                        ? queue_pkg::STAGES_CAP : depth_st;
    wire [3:0] stage_cnt =
        (group == queue_pkg::GROUP_LOWEST) ? queue_pkg::STAGES_LOWEST
      : (group == queue_pkg::GROUP_MIN)    ? queue_pkg::STAGES_MIN
      : (group == queue_pkg::GROUP_BEST)   ? queue_pkg::STAGES_BEST
      : depth_cl;

    ////////////////////////////////////////////////////////////////////////
    // Queue core
    logic [queue_pkg::DATA_W-1:0] mem [queue_pkg::DEPTH];
    logic [queue_pkg::PTR_W-1:0]  wr_ptr_reg;
    logic [queue_pkg::PTR_W-1:0]  rd_ptr_reg;
    logic [4:0]                   used_reg;
    logic                         empty_reg;
    logic                         full_reg;
    logic                         aempty_reg;
    logic                         afull_reg;

    wire       wr_fire   = wr_req & ~full_reg;
    wire       rd_fire   = rd_req & ~empty_reg;
    wire [4:0] used_next = used_reg + {4'h0, wr_fire} - {4'h0, rd_fire};
    wire [queue_pkg::PTR_W-1:0] rd_ptr_next = rd_ptr_reg + {4'h0, rd_fire};
    wire [queue_pkg::DATA_W-1:0] head =
        mem[rd_ptr_next[queue_pkg::IDX_W-1:0]];
    wire [queue_pkg::DATA_W-1:0] cur_word =
        mem[rd_ptr_reg[queue_pkg::IDX_W-1:0]];
    wire [queue_pkg::DATA_W-1:0] first_word = mem[0];
    wire       sclr_any  = ~aresetn | sync_clear;

    // Flags and pointers reset at once on the asynchronous clear
    always_ff @(posedge aclk or posedge async_clear) begin
        if (async_clear) begin
            wr_ptr_reg <= 5'h00;
            rd_ptr_reg <= 5'h00;
            used_reg   <= 5'h00;
            empty_reg  <= 1'b1;
            aempty_reg <= 1'b1;
            full_reg   <= 1'b0;
            afull_reg  <= 1'b0;
        end else if (sclr_any) begin
            wr_ptr_reg <= 5'h00;
            rd_ptr_reg <= 5'h00;
            used_reg   <= 5'h00;
            empty_reg  <= 1'b1;
            aempty_reg <= 1'b1;
            full_reg   <= 1'b0;
            afull_reg  <= 1'b0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + {4'h0, wr_fire};
            rd_ptr_reg <= rd_ptr_next;
            used_reg   <= used_next;
            empty_reg  <= used_next == 5'h00;
            full_reg   <= used_next == queue_pkg::LEVEL_FULL;
            aempty_reg <= used_next < queue_pkg::ALMOST_EMPTY;
            afull_reg  <= used_next >= queue_pkg::ALMOST_FULL;
        end
    end

    always_ff @(posedge aclk) begin
        if (wr_fire)
            mem[wr_ptr_reg[queue_pkg::IDX_W-1:0]] <= wr_data;
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data path
    logic [queue_pkg::DATA_W-1:0] q_reg;
    logic [queue_pkg::DATA_W-1:0] stage_reg;
    logic                         stage_load_reg;
    logic                         la_hold_reg;
    wire                          any_clear = sync_clear | async_clear;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q_reg          <= 8'h00;
            stage_reg      <= 8'h00;
            stage_load_reg <= 1'b0;
            la_hold_reg    <= 1'b0;
        end else if (!la_mode) begin
            la_hold_reg    <= 1'b0;
            stage_load_reg <= rd_fire & ~any_clear;
            if (!oreg) begin
                if (sync_clear)
                    q_reg <= first_word;
                else if (!async_clear && rd_fire)
                    q_reg <= cur_word;
            end else begin
                if (rd_fire && !any_clear)
                    stage_reg <= cur_word;
                if (stage_load_reg && !any_clear)
                    q_reg <= stage_reg;
            end
        end else begin
            stage_load_reg <= 1'b0;
            if (!oreg) begin
                // Word shown after a clear is stale until a real write
                if (sync_clear) begin
                    la_hold_reg <= 1'b1;
                end else if (la_hold_reg) begin
                    la_hold_reg <= 1'b0;
                    q_reg       <= first_word;
                end else begin
                    q_reg       <= head;
                end
            end else begin
                la_hold_reg <= 1'b0;
                if (!any_clear && !empty_reg)
                    q_reg <= head;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Cross-domain level mirror
    logic [queue_pkg::PTR_W-1:0] chain_reg [queue_pkg::MAX_STAGES];
    logic [queue_pkg::PTR_W-1:0] gray_bin;
    logic [4:0]                  remote_reg;
    wire  [queue_pkg::PTR_W-1:0] wr_gray =
        wr_ptr_reg ^ (wr_ptr_reg >> 1);
    wire  [2:0]                  tap_sel = 3'(stage_cnt - 4'h1);
    wire  [queue_pkg::PTR_W-1:0] tap = chain_reg[tap_sel];

    genvar gi;
    generate
        for (gi = 0; gi < queue_pkg::MAX_STAGES; gi++) begin : g_chain
            always_ff @(posedge aclk) begin
                if (sclr_any || async_clear)
                    chain_reg[gi] <= 5'h00;
                else if (gi == 0)
                    chain_reg[gi] <= wr_gray;
                else
                    chain_reg[gi] <= chain_reg[(gi == 0) ? 0 : gi - 1];
            end
        end
        for (gi = 0; gi < queue_pkg::PTR_W; gi++) begin : g_bin
            assign gray_bin[gi] = ^tap[queue_pkg::PTR_W-1:gi];
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (sclr_any || async_clear)
            remote_reg <= 5'h00;
        else
            remote_reg <= gray_bin - rd_ptr_reg;
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupts
    wire [queue_pkg::IRQ_W-1:0] events = {
        rd_req & empty_reg & ~any_clear,
        wr_req & full_reg & ~any_clear,
        rd_fire & ~wr_fire & (used_reg == queue_pkg::LEVEL_ONE),
        wr_fire & ~rd_fire & (used_reg == queue_pkg::LEVEL_LAST)
    };

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_reg <= 4'h0;
            irq_reg      <= 1'b0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~stat_clr) | events;
            irq_reg      <= |(((irq_stat_reg & ~stat_clr) | events)
                              & irq_mask_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read
    wire [31:0] status_word = {23'h0, used_reg, aempty_reg, afull_reg,
                               empty_reg, full_reg};
    wire [31:0] sync_word   = {19'h0, remote_reg, rdepth, stage_cnt};
    wire [31:0] rd_mux =
        (araddr == queue_pkg::CTRL_OFF)     ? {19'h0, ctrl_reg}
      : (araddr == queue_pkg::STATUS_OFF)   ? status_word
      : (araddr == queue_pkg::IRQ_STAT_OFF) ? {28'h0, irq_stat_reg}
      : (araddr == queue_pkg::IRQ_MASK_OFF) ? {28'h0, irq_mask_reg}
      : (araddr == queue_pkg::SYNC_OFF)     ? sync_word
      : 32'h0000_0000;
    wire rd_mapped = (araddr == queue_pkg::CTRL_OFF)
                   | (araddr == queue_pkg::STATUS_OFF)
                   | (araddr == queue_pkg::IRQ_STAT_OFF)
                   | (araddr == queue_pkg::IRQ_MASK_OFF)
                   | (araddr == queue_pkg::SYNC_OFF);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0000_0000;
            rresp_reg   <= queue_pkg::RESP_OKAY;
        end else if (arvalid && arready_reg) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rdata_reg   <= rd_mux;
            rresp_reg   <= rd_mapped ? queue_pkg::RESP_OKAY
                                     : queue_pkg::RESP_SLVERR;
        end else if (rvalid_reg && rready) begin
            rvalid_reg  <= 1'b0;
            arready_reg <= 1'b1;
        end
    end

    assign awready      = awready_reg;
    assign wready       = wready_reg;
    assign bvalid       = bvalid_reg;
    assign bresp        = bresp_reg;
    assign arready      = arready_reg;
    assign rvalid       = rvalid_reg;
    assign rdata        = rdata_reg;
    assign rresp        = rresp_reg;
    assign rd_data      = q_reg;
    assign empty        = empty_reg;
    assign full         = full_reg;
    assign almost_empty = aempty_reg;
    assign almost_full  = afull_reg;
    assign used_words   = used_reg;
    assign remote_level = remote_reg;
    assign irq          = irq_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_sclr_flags;
        sync_clear |=> empty && !full && almost_empty && !almost_full
                       && used_words == 5'h00;
    endproperty
    a_sclr_flags: assert property (p_sclr_flags)
        else $error("flags wrong after sync clear");

    property p_aclr_now;
        async_clear |-> empty && !full && used_words == 5'h00
                        && wr_ptr_reg == 5'h00 && rd_ptr_reg == 5'h00;
    endproperty
    a_aclr_now: assert property (p_aclr_now)
        else $error("async clear not immediate");

    property p_sclr_ptrs;
        sync_clear ##0 !async_clear |=>
            wr_ptr_reg == 5'h00 && rd_ptr_reg == 5'h00;
    endproperty
    a_sclr_ptrs: assert property (p_sclr_ptrs)
        else $error("pointers not zero after sync clear");

    property p_norm_first;
        !la_mode && !oreg && sync_clear |=>
            rd_data == $past(first_word);
    endproperty
    a_norm_first: assert property (p_norm_first)
        else $error("normal sync clear first word missing");

    property p_reg_keep;
        oreg && any_clear |=> $stable(rd_data);
    endproperty
    a_reg_keep: assert property (p_reg_keep)
        else $error("registered output changed on clear");

    property p_la_hold;
        la_mode && !oreg && sync_clear && $stable(ctrl_reg) |=>
            $stable(rd_data) ##1
            (sync_clear || rd_data == $past(first_word));
    endproperty
    a_la_hold: assert property (p_la_hold)
        else $error("look-ahead sync clear timing wrong");

    property p_norm_aclr;
        !la_mode && async_clear && !sync_clear |=> $stable(rd_data);
    endproperty
    a_norm_aclr: assert property (p_norm_aclr)
        else $error("normal async clear changed output");

    property p_la_aclr;
        la_mode && !oreg && async_clear && !sync_clear |=>
            rd_data == $past(first_word);
    endproperty
    a_la_aclr: assert property (p_la_aclr)
        else $error("look-ahead async clear first word missing");

    property p_group_stages;
        (group == queue_pkg::GROUP_LOWEST |-> stage_cnt == 4'h1)
        and (group == queue_pkg::GROUP_MIN |-> stage_cnt == 4'h2)
        and (group == queue_pkg::GROUP_BEST |-> stage_cnt >= 4'h3);
    endproperty
    a_group_stages: assert property (p_group_stages)
        else $error("group stage count wrong");

    property p_depth_scale;
        group == queue_pkg::GROUP_DEPTH && newer && wdepth == 4'h4
            |-> stage_cnt == 4'h2;
    endproperty
    a_depth_scale: assert property (p_depth_scale)
        else $error("scaled pipe depth wrong");

    c_la_sclr: cover property (la_mode && !oreg && sync_clear);
    c_full:    cover property (full && wr_req);
    c_irq:     cover property ($rose(irq));
    c_aclr:    cover property (async_clear && !empty_reg);

endmodule

`default_nettype wire

// ==== verification/queue_user.sv ====
`timescale 1ns/1ps
`default_nettype none

module queue_user (
    input  wire logic       aclk,    // Queue clock
    output logic            wr_req,  // Write request
    output logic [7:0]      wr_data, // Write word
    output logic            rd_req   // Read request
);
    initial begin
        wr_req = 1'b0;
        wr_data = 8'h00;
        rd_req = 1'b0;
    end
    // Entered right after a rising edge; request stays up
    task automatic put(input logic [7:0] d);
        wr_req <= 1'b1;
        wr_data <= d;
        @(posedge aclk);
    endtask
    // Reader trusts a word only after a completed put
    task automatic take();
        rd_req <= 1'b1;
        @(posedge aclk);
    endtask
    // Released data line flips so a stale word never looks held
    task automatic stop();
        wr_req <= 1'b0;
        rd_req <= 1'b0;
        wr_data <= ~wr_data;
    endtask
endmodule

`default_nettype wire

// ==== verification/queue_sync_clear_bench.sv ====
`timescale 1ns/1ps
`default_nettype none

module queue_sync_clear_bench;
logic aclk = 0, aresetn = 0, sync_clear = 0, async_clear = 0;
logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
logic [7:0] awaddr = 0, araddr = 0, wr_data, rd_data, e;
logic [31:0] wdata = 0, rdata, rd;
logic [3:0] wstrb = 0;
logic [1:0] bresp, rresp, rs, bs;
logic awready, wready, bvalid, arready, rvalid, wr_req, rd_req, irq;
logic empty, full, almost_empty, almost_full;
logic [4:0] used_words, remote_level;
int bad_count = 0, total_checks = 0, cyc = 0, wp = 0;
logic [7:0] q_m[$];
logic [7:0] mem_m[16];
logic [31:0] cfg[6] = '{32'h670, 32'h674, 32'h678, 32'h67C, 32'h69C, 32'h6AC};
logic [3:0] st[6] = '{4'h1, 4'h2, 4'h3, 4'h1, 4'h2, 4'h5};
always #4 aclk = ~aclk;
queue_sync_clear dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .sync_clear, .async_clear,
    .wr_req, .wr_data, .rd_req, .rd_data, .empty, .full, .almost_empty,
    .almost_full, .used_words, .remote_level, .irq);
queue_user u (.aclk, .wr_req, .wr_data, .rd_req);
////////////////////////////////////////////////////////////////////////
task automatic chk(input logic [31:0] s, input logic [31:0] x);
    total_checks++;
    if (s !== x) begin
        bad_count++;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
    end
endtask
task automatic summarize();
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
endtask
always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
        bad_count++;
        summarize();
    end
end
task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
        @(posedge aclk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        if (bvalid) break;
    end
    bs = bresp;
    bready <= 1'b0;
endtask
task automatic axr(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
        @(posedge aclk);
        if (arready) arvalid <= 1'b0;
        if (rvalid) break;
    end
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
endtask
task automatic fill(input int n);
    logic [7:0] d;
    @(posedge aclk);
    repeat (n) begin
        d = 8'($urandom);
        u.put(d);
        if (q_m.size() < 16) begin
            q_m.push_back(d);
            mem_m[wp] = d;
            wp = (wp + 1) % 16;
        end
    end
    u.stop();
endtask
task automatic flags();
    #1;
    chk(used_words, q_m.size());
    chk(empty, q_m.size() == 0);
    chk(full, q_m.size() == 16);
    chk(almost_empty, q_m.size() < 2);
    chk(almost_full, q_m.size() >= 14);
endtask
task automatic clr_m();
    q_m.delete();
    wp = 0;
endtask
task automatic la_prep();
    fill(2);
    @(posedge aclk);
    u.take();
    u.stop();
    void'(q_m.pop_front());
    #1;
    chk(rd_data, q_m[0]);
    e = q_m[0];
endtask
////////////////////////////////////////////////////////////////////////
initial begin
    void'($urandom(92));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    flags();
    axr(queue_pkg::CTRL_OFF, rd);
    chk(rd, queue_pkg::CTRL_RESET);
    axr(8'h20, rd);
    chk(rs, queue_pkg::RESP_SLVERR);
    axw(8'h20, 32'h0000_0000);
    chk(bs, queue_pkg::RESP_SLVERR);
    for (int i = 0; i < 6; i++) begin
        axw(queue_pkg::CTRL_OFF, cfg[i]);
        chk(bs, queue_pkg::RESP_OKAY);
        axr(queue_pkg::SYNC_OFF, rd);
        chk(rd[3:0], st[i]);
        chk(rd[7:4], 4'h3);
    end
    axw(queue_pkg::IRQ_MASK_OFF, 32'h4);
    fill(17);
    flags();
    repeat (12) @(posedge aclk);
    chk(remote_level, 5'h10);
    chk(irq, 1'b1);
    axr(queue_pkg::STATUS_OFF, rd);
    chk(rd, 32'h105);
    axr(queue_pkg::IRQ_STAT_OFF, rd);
    chk(rd, 32'h5);
    axw(queue_pkg::IRQ_STAT_OFF, 32'h4);
    axr(queue_pkg::IRQ_STAT_OFF, rd);
    chk(rd, 32'h1);
    chk(irq, 1'b0);
    repeat (3) begin
        @(posedge aclk);
        u.take();
        u.stop();
        #1;
        chk(rd_data, q_m.pop_front());
    end
    @(posedge aclk);
    sync_clear <= 1'b1;
    flags();
    @(posedge aclk);
    sync_clear <= 1'b0;
    clr_m();
    flags();
    chk(rd_data, mem_m[0]);
    e = mem_m[0];
    fill(5);
    async_clear <= 1'b1;
    clr_m();
    flags();
    chk(rd_data, e);
    @(posedge aclk);
    async_clear <= 1'b0;
    axw(queue_pkg::CTRL_OFF, 32'h6AD);
    la_prep();
    @(posedge aclk);
    sync_clear <= 1'b1;
    @(posedge aclk);
    sync_clear <= 1'b0;
    clr_m();
    #1 chk(rd_data, e);
    @(posedge aclk);
    #1 chk(rd_data, mem_m[0]);
    la_prep();
    @(posedge aclk);
    async_clear <= 1'b1;
    clr_m();
    flags();
    @(posedge aclk);
    async_clear <= 1'b0;
    #1 chk(rd_data, mem_m[0]);
    axw(queue_pkg::CTRL_OFF, 32'h672);
    fill(2);
    @(posedge aclk);
    u.take();
    u.stop();
    e = q_m.pop_front();
    @(posedge aclk);
    #1 chk(rd_data, e);
    @(posedge aclk);
    sync_clear <= 1'b1;
    @(posedge aclk);
    sync_clear <= 1'b0;
    clr_m();
    #1 chk(rd_data, e);
    @(posedge aclk);
    async_clear <= 1'b1;
    @(posedge aclk);
    async_clear <= 1'b0;
    #1 chk(rd_data, e);
    flags();
    summarize();
end
endmodule

`default_nettype wire
